// file: verilog/tars_top.sv
// timer paced seven slot converter sequencer with per channel rms
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "tars_consts.svh"
// How it works
// RL1: at start-up watchdog is stopped and the port lock is released
// RL2: oscillator 16 MHz, range 1, freq 4, dividers 1, main and sub from it
// RL3: clock config writes accepted only while unlocked by key; relocked after
// RL4: program memory gets one wait state, written only with its password
// RL5: analogue pins take both function select bits high
// RL6: indicator pins become outputs and are driven high
// RL7: reference on at 2.5 V, then a settling delay before conversions
// RL8: each sample window lasts 64 converter clocks, both fields set alike
// RL9: in multi-sample mode one trigger runs the whole sequence
// RL10: sequence mode field is 01, one channel sequence per trigger
// RL11: sample control comes from the timer, trigger select 3
// RL12: converter clocked from sub-system clock, code 11
// RL13: resolution code 10, results are 12 bits
// RL14: slots 0..6 convert differential channels 0,4,6,8,10,12,14, external refs
// RL15: slot 6 ends the sequence
// RL16: interrupt when slot 6 written and enable bit 6 set
// RL17: sampling timer cleared, starts at 0, 16 bits, sub-system clock
// RL18: timer counts up/down with period 2500
// RL19: compare channel 1 in set/reset mode makes the trigger edge
// RL20: interrupt copies slots, sets data flag, re-enables conversion
// RL21: each sample minus 2048 made absolute, sample counter steps
// RL22: 64 squares summed, divided by 64, square root is the rms
// RL23: after each block counter and sums return to zero
module tars_top (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	input wire logic CONV_DONE_IN,
	input wire logic [11:0] CONV_DATA_IN,
	output logic SAMPLE_OUT,
	output logic CONV_START_OUT,
	output logic [3:0] CONV_CHAN_OUT,
	output logic CONV_EXT_REF_OUT,
	output logic SEQ_IRQ_OUT,
	output logic TIMER_OUT,
	output logic WDT_RUN_OUT,
	output logic PORT_LOCK_OUT,
	output tars_pkg::tars_clk_t CLK_CFG_OUT,
	output logic [3:0] FLASH_WAIT_OUT,
	output logic [15:0] ANA_FUNC_OUT,
	output logic [1:0] IND_DIR_OUT,
	output logic [1:0] IND_OUT,
	output logic REF_ON_OUT,
	output logic [1:0] REF_LEVEL_OUT
);
	tars_pkg::tars_init_t init_st;
	tars_pkg::tars_seq_t seq_st;
	tars_pkg::tars_proc_t proc_st;
	tars_pkg::tars_conv_t conv;
	logic clk_unlocked;
	logic [15:0] fn_low;
	logic [15:0] fn_high;
	logic [11:0] settle_cnt;
	logic run;
	logic [15:0] tcount;
	logic tdown;
	logic [15:0] period;
	logic [15:0] cmp1;
	logic trig;
	logic [6:0] sh_cnt;
	logic [2:0] slot;
	logic [11:0] res [0:6];
	logic [11:0] cp [0:6];
	logic seq_end;
	logic data_avail;
	logic rms_new;
	logic [5:0] sample_cnt;
	logic [2:0] pch;
	logic [3:0] rbit;
	logic [11:0] root;
	logic [11:0] next_root;
	logic [11:0] trial;
	logic [29:0] acc [0:6];
	logic [11:0] rms [0:6];
	logic req;
	logic wr;
	logic [31:0] rd;

	// merges a bus write into an old value under byte enables
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// magnitude of a result after removing the mid-scale offset
	function automatic logic [11:0] mag(input logic [11:0] x);
		logic [12:0] d;
		d = {1'b0, x} - `TARS_MID; // [RL21]
		if (d[12]) begin
			d = 13'h0000 - d;
		end
		return d[11:0];
	endfunction

	// channel number converted by each slot
	function automatic logic [3:0] slot_chan(input logic [2:0] s);
		if (s == 3'h0) begin
			return 4'h0;
		end
		return {s, 1'b0} + 4'h2; // [RL14]
	endfunction

	assign req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
	assign wr = req & WB_WE_IN;

	// start-up sequence and the clock, memory, pin and reference settings
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			init_st <= tars_pkg::IN_WDT;
			WDT_RUN_OUT <= 1'b1;
			PORT_LOCK_OUT <= 1'b1;
			clk_unlocked <= 1'b0;
			CLK_CFG_OUT <= '{`TARS_RANGE_SEL, 3'h0, `TARS_SRC_LPO, `TARS_SRC_LPO,
				`TARS_SRC_LPO, `TARS_DIV_1, `TARS_DIV_1, `TARS_DIV_1};
			FLASH_WAIT_OUT <= 4'h0;
			fn_low <= 16'h0000;
			fn_high <= 16'h0000;
			ANA_FUNC_OUT <= 16'h0000;
			IND_DIR_OUT <= 2'h0;
			IND_OUT <= 2'h0;
			REF_ON_OUT <= 1'b0;
			REF_LEVEL_OUT <= 2'h0;
			settle_cnt <= 12'h000;
			run <= 1'b0;
		end else begin
			ANA_FUNC_OUT <= fn_low & fn_high; // [RL5]
			case (init_st)
				tars_pkg::IN_WDT: begin
					WDT_RUN_OUT <= 1'b0; // [RL1]
					PORT_LOCK_OUT <= 1'b0; // [RL1]
					init_st <= tars_pkg::IN_UNLOCK;
				end
				tars_pkg::IN_UNLOCK: begin
					clk_unlocked <= 1'b1; // [RL3]
					init_st <= tars_pkg::IN_CLK;
				end
				tars_pkg::IN_CLK: begin
					CLK_CFG_OUT <= '{`TARS_RANGE_SEL, `TARS_FREQ_SEL, `TARS_SRC_OSC,
						`TARS_SRC_OSC, `TARS_SRC_LPO, `TARS_DIV_1, `TARS_DIV_1,
						`TARS_DIV_1}; // [RL2]
					FLASH_WAIT_OUT <= `TARS_FLASH_WAIT; // [RL4]
					init_st <= tars_pkg::IN_LOCK;
				end
				tars_pkg::IN_LOCK: begin
					clk_unlocked <= 1'b0; // [RL3]
					init_st <= tars_pkg::IN_PINS;
				end
				tars_pkg::IN_PINS: begin
					fn_low <= `TARS_ANA_MASK; // [RL5]
					fn_high <= `TARS_ANA_MASK;
					IND_DIR_OUT <= `TARS_IND_BITS; // [RL6]
					IND_OUT <= `TARS_IND_BITS;
					REF_ON_OUT <= 1'b1; // [RL7]
					REF_LEVEL_OUT <= `TARS_REF_LVL;
					init_st <= tars_pkg::IN_SETTLE;
				end
				tars_pkg::IN_SETTLE: begin
					settle_cnt <= settle_cnt + 12'h001;
					if (settle_cnt == 12'(`TARS_SETTLE_CYC - 1)) begin
						run <= 1'b1; // [RL7]
						init_st <= tars_pkg::IN_RUN;
					end
				end
				default: begin
					// bus access to key, clock and program memory settings
					if (wr && WB_ADR_IN == `TARS_OFF_KEY && WB_SEL_IN[0]) begin
						clk_unlocked <= (WB_DAT_IN[7:0] == `TARS_CLK_KEY); // [RL3]
					end else if (wr && WB_ADR_IN == `TARS_OFF_CLK && clk_unlocked) begin
						CLK_CFG_OUT <= 22'(merge(32'(CLK_CFG_OUT), WB_DAT_IN,
							WB_SEL_IN)); // [RL3]
					end else if (wr && WB_ADR_IN == `TARS_OFF_FLASH && WB_SEL_IN[1]
						&& WB_DAT_IN[15:8] == `TARS_FLASH_PW) begin
						FLASH_WAIT_OUT <= WB_DAT_IN[3:0]; // [RL4]
					end
				end
			endcase
		end
	end

	// sampling timer, up/down to the period, compare 1 set/reset output
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			tcount <= 16'h0000;
			tdown <= 1'b0;
			period <= `TARS_PERIOD;
			cmp1 <= `TARS_CMP1;
			TIMER_OUT <= 1'b0;
			trig <= 1'b0;
		end else begin
			trig <= 1'b0;
			if (wr && WB_ADR_IN == `TARS_OFF_PERIOD) begin
				period <= 16'(merge(32'(period), WB_DAT_IN, WB_SEL_IN)); // [RL18]
				tcount <= 16'h0000; // [RL17]
				tdown <= 1'b0;
			end else if (run) begin
				if (!tdown && tcount == period) begin
					tdown <= 1'b1; // [RL18]
					tcount <= tcount - 16'h0001;
				end else if (tdown && tcount == 16'h0000) begin
					tdown <= 1'b0;
					tcount <= 16'h0001;
				end else if (tdown) begin
					tcount <= tcount - 16'h0001;
				end else begin
					tcount <= tcount + 16'h0001; // [RL17]
				end
				if (tcount == period) begin
					TIMER_OUT <= 1'b0; // [RL19]
				end else if (tcount == cmp1) begin
					TIMER_OUT <= 1'b1; // [RL19]
					trig <= ~TIMER_OUT; // [RL11]
				end
			end
			if (wr && WB_ADR_IN == `TARS_OFF_CMP1) begin
				cmp1 <= 16'(merge(32'(cmp1), WB_DAT_IN, WB_SEL_IN));
			end
		end
	end

	// converter settings; enable cleared at sequence end, set again by the handler
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			conv <= '{1'b1, `TARS_RES_12, `TARS_SSEL_SUB, `TARS_SHS_TIMER,
				`TARS_SEQ_MODE, 1'b1, 1'b1, `TARS_SHT_64, `TARS_SHT_64, 1'b1,
				1'b0}; // [RL8] [RL10] [RL11] [RL12] [RL13]
		end else if (wr && WB_ADR_IN == `TARS_OFF_CONV) begin
			conv <= 22'(merge(32'(conv), WB_DAT_IN, WB_SEL_IN));
		end else if (SEQ_IRQ_OUT || (init_st == tars_pkg::IN_SETTLE
			&& settle_cnt == 12'(`TARS_SETTLE_CYC - 1))) begin
			conv.enc <= 1'b1; // [RL20]
		end else if (seq_end) begin
			conv.enc <= 1'b0;
		end
	end

	// sequence: sample window, start, wait for result, next slot
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			seq_st <= tars_pkg::SQ_IDLE;
			sh_cnt <= 7'h00;
			slot <= 3'h0;
			SAMPLE_OUT <= 1'b0;
			CONV_START_OUT <= 1'b0;
			CONV_CHAN_OUT <= 4'h0;
			CONV_EXT_REF_OUT <= 1'b1; // [RL14]
			seq_end <= 1'b0;
			SEQ_IRQ_OUT <= 1'b0;
		end else begin
			CONV_START_OUT <= 1'b0;
			seq_end <= 1'b0;
			SEQ_IRQ_OUT <= seq_end & conv.irq_en6; // [RL16]
			case (seq_st)
				tars_pkg::SQ_IDLE: begin
					if (trig && conv.enc && conv.on) begin
						slot <= 3'h0;
						CONV_CHAN_OUT <= slot_chan(3'h0);
						SAMPLE_OUT <= 1'b1;
						sh_cnt <= 7'h00;
						seq_st <= tars_pkg::SQ_SAMPLE;
					end
				end
				tars_pkg::SQ_SAMPLE: begin
					sh_cnt <= sh_cnt + 7'h01;
					if (sh_cnt == `TARS_SH_CYC - 7'h01) begin
						SAMPLE_OUT <= 1'b0; // [RL8]
						CONV_START_OUT <= 1'b1;
						seq_st <= tars_pkg::SQ_WAIT;
					end
				end
				tars_pkg::SQ_WAIT: begin
					if (CONV_DONE_IN) begin
						if (slot == `TARS_LAST_SLOT) begin
							seq_end <= 1'b1; // [RL15]
							seq_st <= tars_pkg::SQ_IDLE;
						end else begin
							slot <= slot + 3'h1;
							CONV_CHAN_OUT <= slot_chan(slot + 3'h1); // [RL14]
							sh_cnt <= 7'h00;
							SAMPLE_OUT <= conv.msc;
							seq_st <= conv.msc ? tars_pkg::SQ_SAMPLE
								: tars_pkg::SQ_HOLD; // [RL9]
						end
					end
				end
				default: begin
					if (trig) begin
						SAMPLE_OUT <= 1'b1;
						seq_st <= tars_pkg::SQ_SAMPLE;
					end
				end
			endcase
		end
	end

	// result slots and the handler copies
	generate
		for (genvar i = 0; i < 7; i++) begin : g_slot
			always_ff @(posedge MCLK_IN) begin
				if (RST_IN) begin
					res[i] <= 12'h000;
					cp[i] <= 12'h000;
				end else begin
					if (seq_st == tars_pkg::SQ_WAIT && CONV_DONE_IN && slot == 3'(i)) begin
						res[i] <= CONV_DATA_IN;
					end
					if (SEQ_IRQ_OUT) begin
						cp[i] <= res[i]; // [RL20]
					end
				end
			end
		end
	endgenerate

	// one square root step
	always_comb begin
		trial = root | (12'h001 << rbit);
		next_root = root;
		if (24'(trial * trial) <= acc[pch][29:6]) begin // [RL22]
			next_root = trial;
		end
	end

	// rms processing: accumulate squares, then root of mean per channel
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			proc_st <= tars_pkg::PR_IDLE;
			data_avail <= 1'b0;
			rms_new <= 1'b0;
			sample_cnt <= 6'h00;
			pch <= 3'h0;
			rbit <= `TARS_ROOT_TOP;
			root <= 12'h000;
			for (int i = 0; i < 7; i++) begin
				acc[i] <= 30'h00000000;
				rms[i] <= 12'h000;
			end
		end else begin
			if (wr && WB_ADR_IN == `TARS_OFF_STATUS && WB_SEL_IN[0] && WB_DAT_IN[1]) begin
				rms_new <= 1'b0;
			end
			case (proc_st)
				tars_pkg::PR_IDLE: begin
					if (data_avail) begin
						data_avail <= 1'b0;
						pch <= 3'h0;
						proc_st <= tars_pkg::PR_ACC;
					end
				end
				tars_pkg::PR_ACC: begin
					acc[pch] <= acc[pch] + 30'(mag(cp[pch]) * mag(cp[pch])); // [RL22]
					if (pch == `TARS_LAST_SLOT) begin
						pch <= 3'h0;
						if (sample_cnt == `TARS_LAST_SAMPLE) begin
							sample_cnt <= 6'h00; // [RL23]
							proc_st <= tars_pkg::PR_ROOT;
						end else begin
							sample_cnt <= sample_cnt + 6'h01; // [RL21]
							proc_st <= tars_pkg::PR_IDLE;
						end
					end else begin
						pch <= pch + 3'h1;
					end
				end
				default: begin
					root <= next_root;
					rbit <= rbit - 4'h1;
					if (rbit == 4'h0) begin
						rms[pch] <= next_root; // [RL22]
						acc[pch] <= 30'h00000000; // [RL23]
						root <= 12'h000;
						rbit <= `TARS_ROOT_TOP;
						pch <= pch + 3'h1;
						if (pch == `TARS_LAST_SLOT) begin
							pch <= 3'h0; // keeps the root step reading a real channel
							rms_new <= 1'b1;
							proc_st <= tars_pkg::PR_IDLE;
						end
					end
				end
			endcase
			if (SEQ_IRQ_OUT) begin
				data_avail <= 1'b1; // [RL20]
			end
		end
	end

	// read data decode
	always_comb begin
		rd = 32'h00000000;
		if (WB_ADR_IN == `TARS_OFF_STATUS) begin
			rd = {26'h0000000, conv.enc, ~PORT_LOCK_OUT, ~WDT_RUN_OUT, run, rms_new,
				data_avail};
		end else if (WB_ADR_IN == `TARS_OFF_KEY) begin
			rd = {31'h00000000, clk_unlocked};
		end else if (WB_ADR_IN == `TARS_OFF_CLK) begin
			rd = 32'(CLK_CFG_OUT);
		end else if (WB_ADR_IN == `TARS_OFF_FLASH) begin
			rd = {28'h0000000, FLASH_WAIT_OUT};
		end else if (WB_ADR_IN == `TARS_OFF_CONV) begin
			rd = 32'(conv);
		end else if (WB_ADR_IN == `TARS_OFF_PERIOD) begin
			rd = {tcount, period};
		end else if (WB_ADR_IN == `TARS_OFF_CMP1) begin
			rd = {16'h0000, cmp1};
		end else if (WB_ADR_IN >= `TARS_OFF_RMS0 && WB_ADR_IN <= `TARS_OFF_RMS6
			&& WB_ADR_IN[1:0] == 2'h0) begin
			rd = {20'h00000, rms[3'(WB_ADR_IN[4:2])]};
		end
	end

	// wishbone answer one cycle after the request, dropped the next cycle
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h00000000;
		end else begin
			WB_ACK_OUT <= req;
			if (req && !WB_WE_IN) begin
				WB_DAT_OUT <= rd;
			end
		end
	end
endmodule

// file: verilog/tars_consts.svh
// constants for the timed converter sequencer with rms result handling
`ifndef TARS_CONSTS_SVH
`define TARS_CONSTS_SVH
// register byte offsets
`define TARS_OFF_STATUS 8'h00
`define TARS_OFF_KEY 8'h04
`define TARS_OFF_CLK 8'h08
`define TARS_OFF_FLASH 8'h0C
`define TARS_OFF_CONV 8'h10
`define TARS_OFF_PERIOD 8'h14
`define TARS_OFF_CMP1 8'h18
`define TARS_OFF_RMS0 8'h20
`define TARS_OFF_RMS6 8'h38
// passwords
`define TARS_CLK_KEY 8'hA5
`define TARS_FLASH_PW 8'h96
// clock system settings
`define TARS_RANGE_SEL 1'h1
`define TARS_FREQ_SEL 3'h4
`define TARS_SRC_OSC 3'h3
`define TARS_SRC_LPO 3'h1
`define TARS_DIV_1 3'h0
`define TARS_FLASH_WAIT 4'h1
// pins and reference
`define TARS_ANA_MASK 16'hFFF3
`define TARS_IND_BITS 2'h3
`define TARS_REF_LVL 2'h3
// converter settings
`define TARS_SHT_64 4'h4
`define TARS_SH_CYC 7'h40
`define TARS_SEQ_MODE 2'h1
`define TARS_SHS_TIMER 3'h3
`define TARS_SSEL_SUB 2'h3
`define TARS_RES_12 2'h2
`define TARS_LAST_SLOT 3'h6
`define TARS_MID 13'h0800
`define TARS_LAST_SAMPLE 6'h3F
`define TARS_ROOT_TOP 4'hB
// sampling timer
`define TARS_PERIOD 16'h09C4
`define TARS_CMP1 16'h04E2
// reference settling time, ns, and clock period, ns
`define TARS_REF_SETTLE_NS 30000
`define TARS_CLK_NS 10
`define TARS_SETTLE_CYC ((`TARS_REF_SETTLE_NS + `TARS_CLK_NS - 1) / `TARS_CLK_NS)
`endif

// file: verilog/tars_pkg.sv
// types for the timed converter sequencer
package tars_pkg;
	typedef struct packed {
		logic range_sel;
		logic [2:0] freq_sel;
		logic [2:0] sub_src;
		logic [2:0] main_src;
		logic [2:0] aux_src;
		logic [2:0] div_aux;
		logic [2:0] div_sub;
		logic [2:0] div_main;
	} tars_clk_t;
	typedef struct packed {
		logic irq_en6;
		logic [1:0] res;
		logic [1:0] clk_sel;
		logic [2:0] trig_sel;
		logic [1:0] seq_mode;
		logic shp;
		logic on;
		logic [3:0] sht1;
		logic [3:0] sht0;
		logic msc;
		logic enc;
	} tars_conv_t;
	typedef enum {IN_WDT, IN_UNLOCK, IN_CLK, IN_LOCK, IN_PINS, IN_SETTLE, IN_RUN} tars_init_t;
	typedef enum {SQ_IDLE, SQ_SAMPLE, SQ_WAIT, SQ_HOLD} tars_seq_t;
	typedef enum {PR_IDLE, PR_ACC, PR_ROOT} tars_proc_t;
endpackage

// file: bench/tars_conv_model.sv
// behavioural converter that answers each conversion start with one result
`timescale 1ns/100ps
module tars_conv_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic [11:0] data_next_in,
	input wire logic [2:0] delay_next_in,
	output logic done_out = 1'b0,
	output logic [11:0] data_out = 12'h000
);
	logic busy;
	logic [2:0] cnt;
	logic [11:0] held;
	// wait a chosen number of cycles, then present one result for one cycle
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (rst_in) begin
			busy <= 1'b0;
			data_out <= 12'hA5A;
		end else if (start_in) begin
			busy <= 1'b1;
			cnt <= delay_next_in;
			held <= data_next_in;
		end else if (busy && cnt == 3'h0) begin
			busy <= 1'b0;
			done_out <= 1'b1;
			data_out <= held;
		end else begin
			cnt <= cnt - 3'h1;
			data_out <= ~data_out;  // released line never keeps the last result
		end
	end
endmodule

// file: bench/tars_checker.sv
// concurrent checks on the converter sequencer ports
`timescale 1ns/100ps
module tars_checker (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_ACK_OUT,
	input wire logic CONV_DONE_IN,
	input wire logic SAMPLE_OUT,
	input wire logic CONV_START_OUT,
	input wire logic [3:0] CONV_CHAN_OUT,
	input wire logic SEQ_IRQ_OUT,
	input wire logic TIMER_OUT,
	input wire logic WDT_RUN_OUT,
	input wire logic PORT_LOCK_OUT,
	input wire logic REF_ON_OUT,
	input wire logic [1:0] IND_OUT,
	input wire logic [15:0] ANA_FUNC_OUT
);
	logic [6:0] win_cnt;
	logic [11:0] ref_cnt;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	function automatic logic [3:0] next_chan(input logic [3:0] c);
		return (c == 4'h0) ? 4'h4 : ((c == 4'hE) ? 4'h0 : c + 4'h2);
	endfunction
	// length of the current sample window
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN || !SAMPLE_OUT) begin
			win_cnt <= 7'h00;
		end else if (win_cnt != 7'h7F) begin
			win_cnt <= win_cnt + 7'h01;
		end
	end
	// cycles since the reference came on, saturating
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN || !REF_ON_OUT) begin
			ref_cnt <= 12'h000;
		end else if (ref_cnt != 12'hFFF) begin
			ref_cnt <= ref_cnt + 12'h001;
		end
	end
	sequence window_end_s;
		$fell(SAMPLE_OUT) ##0 CONV_START_OUT;
	endsequence
	chk_window_len: assert property ($fell(SAMPLE_OUT) |-> win_cnt == 7'h40)
		else $error("sample window not 64 cycles");
	chk_start_after: assert property ($rose(SAMPLE_OUT) |-> ##64 window_end_s)
		else $error("no conversion start after window");
	chk_next_slot: assert property (CONV_DONE_IN && CONV_CHAN_OUT != 4'hE |=> SAMPLE_OUT)
		else $error("next slot did not sample");
	chk_chan_order: assert property ($changed(CONV_CHAN_OUT) |->
		CONV_CHAN_OUT == next_chan($past(CONV_CHAN_OUT))) else $error("channel order wrong");
	chk_first_trig: assert property ($rose(SAMPLE_OUT) && CONV_CHAN_OUT == 4'h0 |->
		$past(TIMER_OUT)) else $error("sequence began without timer");
	chk_irq_cause: assert property (SEQ_IRQ_OUT |->
		$past(CONV_DONE_IN, 2) && $past(CONV_CHAN_OUT, 2) == 4'hE) else $error("stray irq");
	chk_irq_pulse: assert property (SEQ_IRQ_OUT |=> !SEQ_IRQ_OUT)
		else $error("irq longer than one cycle");
	chk_ref_settle: assert property ($rose(SAMPLE_OUT) |-> ref_cnt >= 12'hBB8)
		else $error("sampling before reference settled");
	chk_init_release: assert property ($fell(WDT_RUN_OUT) |-> !PORT_LOCK_OUT)
		else $error("lock kept after watchdog stop");
	chk_pins_set: assert property ($fell(PORT_LOCK_OUT) |-> ##[1:6]
		(IND_OUT == 2'h3 && ANA_FUNC_OUT == 16'hFFF3 && REF_ON_OUT)) else $error("pins not set");
	chk_bus_ack: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("bus request not acknowledged");
endmodule
bind tars_top tars_checker u_chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .CONV_DONE_IN(CONV_DONE_IN),
	.SAMPLE_OUT(SAMPLE_OUT), .CONV_START_OUT(CONV_START_OUT), .CONV_CHAN_OUT(CONV_CHAN_OUT),
	.SEQ_IRQ_OUT(SEQ_IRQ_OUT), .TIMER_OUT(TIMER_OUT), .WDT_RUN_OUT(WDT_RUN_OUT),
	.PORT_LOCK_OUT(PORT_LOCK_OUT), .REF_ON_OUT(REF_ON_OUT), .IND_OUT(IND_OUT),
	.ANA_FUNC_OUT(ANA_FUNC_OUT));

// file: bench/test_tars_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "tars_consts.svh"
module test_tars_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, v, rd_bus, rnd = 32'h00013EF5;
	logic [11:0] p_data = 12'h000, cdat;
	logic [2:0] p_dly = 3'h0;
	logic ack, samp, start, done, irq, tmr, wdt, lock, extref, refon;
	logic [3:0] chan, fwait;
	logic [15:0] ana;
	logic [1:0] idir, iout, rlvl;
	tars_pkg::tars_clk_t clk_cfg, ecfg;
	tars_pkg::tars_conv_t conv;
	int errors = 0, checks = 0, cycles = 0, irq_cnt = 0, i, d;
	longint acc [7];
	int cnt [7], nb [7], exp_rms [14];
	tars_top dut (.MCLK_IN(mclk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
		.WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rd_bus), .WB_ACK_OUT(ack),
		.CONV_DONE_IN(done), .CONV_DATA_IN(cdat), .SAMPLE_OUT(samp), .CONV_START_OUT(start),
		.CONV_CHAN_OUT(chan), .CONV_EXT_REF_OUT(extref), .SEQ_IRQ_OUT(irq), .TIMER_OUT(tmr),
		.WDT_RUN_OUT(wdt), .PORT_LOCK_OUT(lock), .CLK_CFG_OUT(clk_cfg), .FLASH_WAIT_OUT(fwait),
		.ANA_FUNC_OUT(ana), .IND_DIR_OUT(idir), .IND_OUT(iout), .REF_ON_OUT(refon),
		.REF_LEVEL_OUT(rlvl));
	tars_conv_model model (.clk_in(mclk), .rst_in(rst), .start_in(start), .data_next_in(p_data),
		.delay_next_in(p_dly), .done_out(done), .data_out(cdat));
	always #5 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int isqrt(input longint x);
		int r;
		r = 0;
		while (longint'(r + 1) * (r + 1) <= x) r++;
		return r;
	endfunction
	task automatic close_out;
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic bus cycle, held until acknowledged
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= dv;
		sel <= 4'hF;
		do @(posedge mclk); while (ack !== 1'b1);
		rdat = rd_bus;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// random converter data with full-scale corners, timeout and expected rms
	always @(posedge mclk) begin
		rnd <= lfsr(rnd);
		p_data <= (rnd[3:1] == 3'h0) ? {12{rnd[0]}} : rnd[19:8];
		p_dly <= rnd[6:4];
		cycles++;
		if (cycles > 95000) begin
			errors++;
			close_out();
		end
		if (!rst && irq === 1'b1) irq_cnt++;
		if (!rst && done === 1'b1) begin
			i = (chan == 4'h0) ? 0 : int'(chan) / 2 - 1;
			d = int'(cdat) - 2048;
			acc[i] += d * d;
			cnt[i]++;
			if (cnt[i] == 64) begin
				if (nb[i] < 2) exp_rms[nb[i] * 7 + i] = isqrt(acc[i] / 64);
				nb[i]++;
				acc[i] = 0;
				cnt[i] = 0;
			end
		end
	end
	initial begin
		for (int k = 0; k < 7; k++) begin
			acc[k] = 0;
			cnt[k] = 0;
			nb[k] = 0;
		end
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		do wb(1'b0, `TARS_OFF_STATUS, 32'h0); while (rdat[2] !== 1'b1);
		chk(rdat[5:2], 4'hF);
		chk({wdt, lock, extref, refon, rlvl, iout, idir, ana}, {4'h3, 6'h3F, 16'hFFF3});
		wb(1'b0, `TARS_OFF_PERIOD, 32'h0);
		chk(rdat[15:0], 16'h09C4);
		wb(1'b0, `TARS_OFF_CONV, 32'h0);
		conv = rdat[21:0];
		chk({conv.seq_mode, conv.trig_sel, conv.clk_sel, conv.res, conv.sht0, conv.sht1, conv.msc,
			conv.on, conv.shp}, {2'h1, 3'h3, 2'h3, 2'h2, 4'h4, 4'h4, 3'h7});
		conv.irq_en6 = 1'b1;
		wb(1'b1, `TARS_OFF_CONV, 32'(conv));
		// set/reset output rises once per up/down cycle, 560 cycles, above one sequence
		wb(1'b1, `TARS_OFF_CMP1, 32'h0000008C);
		wb(1'b1, `TARS_OFF_PERIOD, 32'h00000118);
		ecfg = '{range_sel: 1'b1, freq_sel: 3'h4, sub_src: 3'h3, main_src: 3'h3, aux_src: 3'h1,
			default: '0};
		v = rnd;
		wb(1'b1, `TARS_OFF_CLK, v);
		wb(1'b0, `TARS_OFF_CLK, 32'h0);
		chk(rdat[21:0], ecfg);
		chk(clk_cfg, ecfg);
		wb(1'b1, `TARS_OFF_KEY, 32'h000000A5);
		wb(1'b1, `TARS_OFF_CLK, v);
		wb(1'b0, `TARS_OFF_CLK, 32'h0);
		chk(rdat[21:0], v[21:0]);
		wb(1'b1, `TARS_OFF_CLK, 32'(ecfg));
		wb(1'b1, `TARS_OFF_KEY, 32'h0);
		wb(1'b1, `TARS_OFF_CLK, v);
		wb(1'b0, `TARS_OFF_CLK, 32'h0);
		chk(rdat[21:0], ecfg);
		wb(1'b1, `TARS_OFF_FLASH, 32'h00009603);
		wb(1'b1, `TARS_OFF_FLASH, 32'h00000007);
		wb(1'b0, `TARS_OFF_FLASH, 32'h0);
		chk({rdat[3:0], fwait}, 8'h33);
		wb(1'b1, `TARS_OFF_FLASH, 32'h00009601);
		wb(1'b0, `TARS_OFF_FLASH, 32'h0);
		chk({rdat[3:0], fwait}, 8'h11);
		wb(1'b1, 8'hF0, v);
		wb(1'b0, 8'hF0, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, `TARS_OFF_PERIOD, 32'h0);
		chk({rdat[15:0], 1'(rdat[31:16] <= 16'h0118)}, 17'h00231);
		// two blocks of 64 sequences, each with fresh sums
		for (int b = 0; b < 2; b++) begin
			do wb(1'b0, `TARS_OFF_STATUS, 32'h0); while (rdat[1] !== 1'b1);
			for (int k = 0; k < 7; k++) begin
				wb(1'b0, `TARS_OFF_RMS0 + 8'(4 * k), 32'h0);
				chk(rdat, 32'(exp_rms[b * 7 + k]));
			end
			wb(1'b1, `TARS_OFF_STATUS, 32'h00000002);
			wb(1'b0, `TARS_OFF_STATUS, 32'h0);
			chk(rdat[1], 1'b0);
		end
		chk(32'(irq_cnt >= 128), 32'h1);
		close_out();
	end
endmodule
